// ### dv/pcr_regs_tb.sv
module pcr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] data;
    } pcr_row_t;

    localparam logic [7:0] RST [11:19] = '{pcr_pkg::RST_SLOW_OSC, pcr_pkg::RST_PWM_T1,
        pcr_pkg::RST_SLOW_TMR, pcr_pkg::RST_TOUCH, pcr_pkg::RST_TEST, pcr_pkg::RST_CLK,
        pcr_pkg::RST_DISP, pcr_pkg::RST_PORT_D, pcr_pkg::RST_PORT_E};
    localparam logic [7:0] MSK [11:19] = '{pcr_pkg::MSK_SLOW_OSC, pcr_pkg::MSK_PWM_T1,
        pcr_pkg::MSK_SLOW_TMR, pcr_pkg::MSK_TOUCH, pcr_pkg::MSK_TEST, pcr_pkg::MSK_CLK,
        pcr_pkg::MSK_DISP, pcr_pkg::MSK_PORT_D, pcr_pkg::MSK_PORT_E};
    // Every register is visited; 0x0B ends with all pins enabled for the 0x0C rows
    localparam pcr_row_t ROWS [0:30] = '{'{8'h0B, 8'h35}, '{8'h0B, 8'h4A}, '{8'h0B, 8'hFF},
        '{8'h0B, 8'h08}, '{8'h0B, 8'h04}, '{8'h0B, 8'h10}, '{8'h0B, 8'h1C}, '{8'h0C, 8'h3F},
        '{8'h0C, 8'h14}, '{8'h0C, 8'h28}, '{8'h0C, 8'h00}, '{8'h0D, 8'h75}, '{8'h0D, 8'h0A},
        '{8'h0E, 8'hFF}, '{8'h0E, 8'h6E}, '{8'h0E, 8'h90}, '{8'h0E, 8'h0F}, '{8'h0F, 8'hFF},
        '{8'h0F, 8'h01}, '{8'h10, 8'hFF}, '{8'h10, 8'h2A}, '{8'h10, 8'h15}, '{8'h10, 8'h40},
        '{8'h11, 8'h00}, '{8'h11, 8'h55}, '{8'h11, 8'hAA}, '{8'h11, 8'hFE}, '{8'h12, 8'hFF},
        '{8'h12, 8'h15}, '{8'h13, 8'hFF}, '{8'h13, 8'h0A}};

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pwm_a_wave = 1'b0;
    logic pwm_b_wave = 1'b0;
    logic buzzer_wave = 1'b0;
    logic slow_timer_tick = 1'b0;
    logic buzzer_pin_out, buzzer_pin_oe, pwm_a_pin_out, pwm_a_pin_oe;
    logic pwm_b_pin_out, pwm_b_pin_oe, slow_timer_irq, display_clock_tick;
    pcr_pkg::pcr_cfg_t cfg;
    pcr_pkg::pcr_cfg_t pre_cfg;
    logic [7:0] shadow [11:19];
    logic [31:0] rd;
    int fail_count = 0;
    int checks_done = 0;
    int ni, nd;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    always #5 hclk = ~hclk;

    pcr_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_a_wave(pwm_a_wave),
        .pwm_b_wave(pwm_b_wave), .buzzer_wave(buzzer_wave), .slow_timer_tick(slow_timer_tick),
        .buzzer_pin_out(buzzer_pin_out), .buzzer_pin_oe(buzzer_pin_oe),
        .pwm_a_pin_out(pwm_a_pin_out), .pwm_a_pin_oe(pwm_a_pin_oe),
        .pwm_b_pin_out(pwm_b_pin_out), .pwm_b_pin_oe(pwm_b_pin_oe),
        .slow_timer_irq(slow_timer_irq), .display_clock_tick(display_clock_tick), .cfg(cfg));

    // Repack the struct into the register byte layout
    function automatic logic [7:0] cfg_byte(input pcr_pkg::pcr_cfg_t c, input int i);
        case (i)
            11: return {1'b0, c.slow_rc_freq_select, c.buzzer_pin_enable, c.pwm_a_pin_enable,
                c.pwm_b_pin_enable, c.watchdog_wake_period};
            12: return {2'b00, c.buzzer_count_enable, c.pwm_a_invert, c.pwm_a_prescale,
                c.timer_b_capture_mode, c.timer_b_clock_select};
            13: return {1'b0, c.ext_irq_d_edge, c.ext_irq_a_edge, c.slow_timer_clock_select,
                c.slow_timer_irq_divide, c.display_clock_divide};
            14: return {c.wake_timer_from_touch, c.timer_a_from_touch, c.touch_osc_speed,
                c.touch_channel_select};
            15: return {6'h00, c.test_bits};
            16: return {1'b0, c.crystal_high_gain, c.irq_context_autosave, c.cpu_on_slow_clock,
                c.fast_clock_stop, c.slow_clock_enable, c.slow_clock_type};
            17: return {c.display_current_level, c.display_duty_select, c.display_bias_select,
                c.display_brightness};
            18: return {2'b00, c.port_d_push_pull};
            default: return {4'h0, c.port_e_push_pull};
        endcase
    endfunction : cfg_byte

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // Bounded wait for a ready edge; a stuck slave shows as a mismatch
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        chk("hready", 1, hready);
    endtask : wait_rdy

    task automatic xfer(input logic w, input logic [31:0] a, input logic [2:0] sz,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= sz;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        pre_cfg = cfg;
        chk("hresp", 0, hresp);
    endtask : xfer

    task automatic check_all;
        for (int i = 11; i <= 19; i++) chk("cfg", shadow[i], cfg_byte(cfg, i));
    endtask : check_all

    // Write, confirm nothing moved early, then that everything landed together
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [2:0] sz);
        int i;
        i = int'(a[9:2]);
        xfer(1'b1, a, sz, {24'h00_0000, d}, rd);
        if (i >= 11 && i <= 19) chk("early", shadow[i], cfg_byte(pre_cfg, i));
        #1;
        if (a[1:0] == 2'b00 && a[31:10] == 0 && i >= 11 && i <= 19 && sz == 3'b010) begin
            shadow[i] = d & MSK[i];
        end
        check_all();
    endtask : wr

    // Pins need one more cycle after the field; both wave levels are tried
    task automatic pins;
        logic [7:0] e;
        logic inv;
        e = shadow[11];
        inv = shadow[12][4];
        for (int w = 0; w < 2; w++) begin
            @(posedge hclk);
            buzzer_wave <= w[0];
            pwm_a_wave <= ~w[0];
            pwm_b_wave <= w[0];
            repeat (3) @(posedge hclk);
            chk("pins", {e[4] & w[0], e[4], e[3] & (~w[0] ^ inv), e[3], e[2] & w[0], e[2]},
                {buzzer_pin_out, buzzer_pin_oe, pwm_a_pin_out, pwm_a_pin_oe, pwm_b_pin_out,
                pwm_b_pin_oe});
        end
    endtask : pins

    // Ticks two cycles apart, pulses counted until the pipeline drains
    task automatic ticks(input int n);
        ni = 0;
        nd = 0;
        for (int k = 0; k < 2 * n + 6; k++) begin
            @(posedge hclk);
            slow_timer_tick <= (k < 2 * n) && !k[0];
            if (slow_timer_irq === 1'b1) ni++;
            if (display_clock_tick === 1'b1) nd++;
        end
    endtask : ticks

    // Cuts a hang short beyond the expected run of about 70k cycles
    initial begin
        #900us;
        fail_count++;
        final_report();
    end

    initial begin
        shadow = RST;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        check_all();
        chk("ready", 1, hreadyout);
        pins();
        foreach (ROWS[j]) begin
            wr({22'h0, ROWS[j].idx, 2'b00}, ROWS[j].data, 3'b010);
            pins();
        end
        // Back-to-back writes: second address phase overlaps first data phase
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= 32'h0000_0040;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        wait_rdy();
        haddr <= 32'h0000_0044;
        hwdata <= 32'h0000_0015;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= 32'h0000_0055;
        wait_rdy();
        #1;
        shadow[16] = 8'h15;
        shadow[17] = 8'h55;
        check_all();
        xfer(1'b0, 32'h0000_0050, 3'b010, 32'h0, rd);
        chk("status", 33, rd);
        xfer(1'b0, 32'h0000_002C, 3'b010, 32'h0, rd);
        chk("rdata", 0, rd);
        // Unmapped and sub-word writes must leave every field alone
        wr(32'h0000_0054, 8'hFF, 3'b010);
        wr(32'h0000_0028, 8'hFF, 3'b010);
        wr(32'h0000_002C, 8'h00, 3'b000);
        for (int d = 0; d < 4; d++) begin
            wr(32'h0000_0034, 8'h0C | 8'(d), 3'b010);
            ticks(256);
            chk("irq", 2, ni);
            chk("disp", 256 >> (7 - d), nd);
        end
        wr(32'h0000_0034, 8'h08, 3'b010);
        ticks(8192);
        chk("irq", 1, ni);
        wr(32'h0000_0034, 8'h04, 3'b010);
        ticks(16384);
        chk("irq", 1, ni);
        // Slowest division: the count passes 0x7FFF once in this window
        wr(32'h0000_0034, 8'h00, 3'b010);
        ticks(8192);
        chk("irq", 1, ni);
        chk("disp", 64, nd);
        // Second reset in mid-run restores every default at once
        @(posedge hclk);
        hresetn <= 1'b0;
        #1;
        shadow = RST;
        check_all();
        chk("pins", 0, {buzzer_pin_oe, pwm_a_pin_oe, pwm_b_pin_oe});
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        wr(32'h0000_0048, 8'h2A, 3'b010);
        // Write counter restarts from zero after the reset
        xfer(1'b0, 32'h0000_0050, 3'b010, 32'h0, rd);
        chk("status", 1, rd);
        final_report();
    end
endmodule : pcr_regs_tb

// ### hw/pcr_pkg.sv
package pcr_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_SLOW_OSC = 8'h0B;
    localparam logic [7:0] IDX_PWM_T1 = 8'h0C;
    localparam logic [7:0] IDX_SLOW_TMR = 8'h0D;
    localparam logic [7:0] IDX_TOUCH = 8'h0E;
    localparam logic [7:0] IDX_TEST = 8'h0F;
    localparam logic [7:0] IDX_CLK = 8'h10;
    localparam logic [7:0] IDX_DISP = 8'h11;
    localparam logic [7:0] IDX_PORT_D = 8'h12;
    localparam logic [7:0] IDX_PORT_E = 8'h13;
    localparam logic [7:0] IDX_STATUS = 8'h14;

    // Reset values of each register
    localparam logic [7:0] RST_SLOW_OSC = 8'h63;
    localparam logic [7:0] RST_PWM_T1 = 8'h00;
    localparam logic [7:0] RST_SLOW_TMR = 8'h00;
    localparam logic [7:0] RST_TOUCH = 8'h0F;
    localparam logic [7:0] RST_TEST = 8'h00;
    localparam logic [7:0] RST_CLK = 8'h40;
    localparam logic [7:0] RST_DISP = 8'hFE;
    localparam logic [7:0] RST_PORT_D = 8'h00;
    localparam logic [7:0] RST_PORT_E = 8'h00;

    // Implemented bit masks; other bits are kept at zero
    localparam logic [7:0] MSK_SLOW_OSC = 8'h7F;
    localparam logic [7:0] MSK_PWM_T1 = 8'h3F;
    localparam logic [7:0] MSK_SLOW_TMR = 8'h7F;
    localparam logic [7:0] MSK_TOUCH = 8'hFF;
    localparam logic [7:0] MSK_TEST = 8'h03;
    localparam logic [7:0] MSK_CLK = 8'h7F;
    localparam logic [7:0] MSK_DISP = 8'hFF;
    localparam logic [7:0] MSK_PORT_D = 8'h3F;
    localparam logic [7:0] MSK_PORT_E = 8'h0F;

    // Timing
    localparam int CLK_PERIOD_NS = 10;

    typedef struct packed {
        logic [1:0] slow_rc_freq_select;
        logic buzzer_pin_enable;
        logic pwm_a_pin_enable;
        logic pwm_b_pin_enable;
        logic [1:0] watchdog_wake_period;
        logic buzzer_count_enable;
        logic pwm_a_invert;
        logic [1:0] pwm_a_prescale;
        logic timer_b_capture_mode;
        logic timer_b_clock_select;
        logic ext_irq_d_edge;
        logic ext_irq_a_edge;
        logic slow_timer_clock_select;
        logic [1:0] slow_timer_irq_divide;
        logic [1:0] display_clock_divide;
        logic wake_timer_from_touch;
        logic timer_a_from_touch;
        logic [1:0] touch_osc_speed;
        logic [3:0] touch_channel_select;
        logic [1:0] test_bits;
        logic crystal_high_gain;
        logic irq_context_autosave;
        logic cpu_on_slow_clock;
        logic fast_clock_stop;
        logic slow_clock_enable;
        logic [1:0] slow_clock_type;
        logic [1:0] display_current_level;
        logic [2:0] display_duty_select;
        logic display_bias_select;
        logic [1:0] display_brightness;
        logic [5:0] port_d_push_pull;
        logic [3:0] port_e_push_pull;
    } pcr_cfg_t;

    typedef enum logic [1:0] {
        PCR_IDLE = 2'b01,
        PCR_WDATA = 2'b10
    } pcr_state_t;
endpackage : pcr_pkg

// ### hw/pcr_regs.sv
// Contract
// - Slow RC select: 00=128K, 01=32K, 10=8K, 11=2K; resets to 11
// - Buzzer enable routes buzzer wave to buzzer pin, else no buzzer signal
// - PWM A enable drives PWM A pin, else pin stays general I/O
// - PWM B enable drives PWM B pin, else pin stays general I/O
// - Watchdog period codes 00..11 give 0.875, 1.75, 28, 112 ms; reset 11
// - Buzzer timer counts only while count enable is one; reset zero
// - PWM A invert bit drives inverted waveform when one
// - PWM A prescale divides oscillator by 1, 2, 4 or 8
// - Timer B capture bit measures interval between like capture edges
// - Timer B clock: oscillator when one, oscillator/2 when zero
// - Each external irq edge bit: falling at zero, rising at one
// - Slow timer clock: slow clock at zero, core clock/128 at one
// - Slow timer irq every 32768, 16384, 8192 or 128 timer clocks
// - Display clock is slow timer clock divided by 128, 64, 32, 16
// - Wake timer touch bit clocks wake timer from touch oscillator
// - Timer A touch bit selects touch oscillator, else core or ext clock
// - Touch channel 0..14 selects channel, 1111 none (reset); speed 00 fastest
// - Autosave bit saves and restores context on interrupt entry and return
// - Clock bits: CPU on slow, stop fast, slow enable; high gain resets one
// - Slow clock type: crystal, internal RC, external RC, touch clock
// - Display duty 000 static to 111 1/8, reset 111; bias 0=1/2, 1=1/3
// - Port type bits: one push-pull, zero open-drain or input; reset zero
//
// The AHB-Lite interface to the registers is this design's own decision.
module pcr_regs #(
    parameter int SLOW_TIMER_IRQ_BITS = 15
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pwm_a_wave,
    input wire logic pwm_b_wave,
    input wire logic buzzer_wave,
    input wire logic slow_timer_tick,
    output logic buzzer_pin_out,
    output logic buzzer_pin_oe,
    output logic pwm_a_pin_out,
    output logic pwm_a_pin_oe,
    output logic pwm_b_pin_out,
    output logic pwm_b_pin_oe,
    output logic slow_timer_irq,
    output logic display_clock_tick,
    output pcr_pkg::pcr_cfg_t cfg
);
    pcr_pkg::pcr_state_t state;
    logic [7:0] wr_idx;
    logic [7:0] wdat;
    logic wr_go;
    logic [14:0] tmr_cnt;
    logic [14:0] irq_mask;
    logic [6:0] disp_mask;
    logic [7:0] wr_count;

    // Word index from a byte address, zero when outside the map
    function automatic logic [7:0] pcr_index(input logic [31:0] a);
        pcr_index = (a[31:10] == 22'h000000 && a[1:0] == 2'h0) ? a[9:2] : 8'h00;
    endfunction : pcr_index

    // Divide mask from a two-bit code: low bits that must all be set
    function automatic logic [14:0] pcr_irq_mask(input logic [1:0] c);
        case (c)
            2'b00: pcr_irq_mask = 15'h7FFF;
            2'b01: pcr_irq_mask = 15'h3FFF;
            2'b10: pcr_irq_mask = 15'h1FFF;
            default: pcr_irq_mask = 15'h007F;
        endcase
    endfunction : pcr_irq_mask

    assign irq_mask = pcr_irq_mask(cfg.slow_timer_irq_divide);
    assign disp_mask = 7'h7F >> cfg.display_clock_divide;
    assign wr_go = (state == pcr_pkg::PCR_WDATA);

    // Bus front end: zero wait states, OKAY always, address latched in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= pcr_pkg::PCR_IDLE;
            wr_idx <= 8'h00;
        end else if (hready && hsel && htrans[1] && hwrite && hsize == 3'h2) begin
            state <= pcr_pkg::PCR_WDATA;
            wr_idx <= pcr_index(haddr);
        end else if (hready) begin
            state <= pcr_pkg::PCR_IDLE;
        end
    end

    assign wdat = hwdata[7:0];

    // Fixed response; registers are write-only so reads show only the status word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data: status word counts accepted writes, everything else reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= (pcr_index(haddr) == pcr_pkg::IDX_STATUS) ?
                {24'h000000, wr_count} : 32'h00000000;
        end
    end

    // Count of register writes, lets software confirm a write landed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_count <= 8'h00;
        end else if (wr_go && wr_idx >= pcr_pkg::IDX_SLOW_OSC &&
                     wr_idx <= pcr_pkg::IDX_PORT_E) begin
            wr_count <= wr_count + 8'h01;
        end
    end

    // Whole register loads at once so fields never mix old and new values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {cfg.slow_rc_freq_select, cfg.buzzer_pin_enable, cfg.pwm_a_pin_enable,
             cfg.pwm_b_pin_enable, cfg.watchdog_wake_period} <= pcr_pkg::RST_SLOW_OSC[6:0];
            {cfg.buzzer_count_enable, cfg.pwm_a_invert, cfg.pwm_a_prescale,
             cfg.timer_b_capture_mode, cfg.timer_b_clock_select} <= pcr_pkg::RST_PWM_T1[5:0];
            {cfg.ext_irq_d_edge, cfg.ext_irq_a_edge, cfg.slow_timer_clock_select,
             cfg.slow_timer_irq_divide, cfg.display_clock_divide} <= pcr_pkg::RST_SLOW_TMR[6:0];
            {cfg.wake_timer_from_touch, cfg.timer_a_from_touch, cfg.touch_osc_speed,
             cfg.touch_channel_select} <= pcr_pkg::RST_TOUCH;
            cfg.test_bits <= pcr_pkg::RST_TEST[1:0];
            {cfg.crystal_high_gain, cfg.irq_context_autosave, cfg.cpu_on_slow_clock,
             cfg.fast_clock_stop, cfg.slow_clock_enable,
             cfg.slow_clock_type} <= pcr_pkg::RST_CLK[6:0];
            {cfg.display_current_level, cfg.display_duty_select, cfg.display_bias_select,
             cfg.display_brightness} <= pcr_pkg::RST_DISP;
            cfg.port_d_push_pull <= pcr_pkg::RST_PORT_D[5:0];
            cfg.port_e_push_pull <= pcr_pkg::RST_PORT_E[3:0];
        end else if (wr_go) begin
            case (wr_idx)
                pcr_pkg::IDX_SLOW_OSC: begin
                    {cfg.slow_rc_freq_select, cfg.buzzer_pin_enable, cfg.pwm_a_pin_enable,
                     cfg.pwm_b_pin_enable,
                     cfg.watchdog_wake_period} <= wdat[6:0] & pcr_pkg::MSK_SLOW_OSC[6:0];
                end
                pcr_pkg::IDX_PWM_T1: begin
                    {cfg.buzzer_count_enable, cfg.pwm_a_invert, cfg.pwm_a_prescale,
                     cfg.timer_b_capture_mode,
                     cfg.timer_b_clock_select} <= wdat[5:0] & pcr_pkg::MSK_PWM_T1[5:0];
                end
                pcr_pkg::IDX_SLOW_TMR: begin
                    {cfg.ext_irq_d_edge, cfg.ext_irq_a_edge, cfg.slow_timer_clock_select,
                     cfg.slow_timer_irq_divide,
                     cfg.display_clock_divide} <= wdat[6:0] & pcr_pkg::MSK_SLOW_TMR[6:0];
                end
                pcr_pkg::IDX_TOUCH: begin
                    {cfg.wake_timer_from_touch, cfg.timer_a_from_touch, cfg.touch_osc_speed,
                     cfg.touch_channel_select} <= wdat & pcr_pkg::MSK_TOUCH;
                end
                pcr_pkg::IDX_TEST: begin
                    cfg.test_bits <= wdat[1:0] & pcr_pkg::MSK_TEST[1:0];
                end
                pcr_pkg::IDX_CLK: begin
                    {cfg.crystal_high_gain, cfg.irq_context_autosave, cfg.cpu_on_slow_clock,
                     cfg.fast_clock_stop, cfg.slow_clock_enable,
                     cfg.slow_clock_type} <= wdat[6:0] & pcr_pkg::MSK_CLK[6:0];
                end
                pcr_pkg::IDX_DISP: begin
                    {cfg.display_current_level, cfg.display_duty_select,
                     cfg.display_bias_select,
                     cfg.display_brightness} <= wdat & pcr_pkg::MSK_DISP;
                end
                pcr_pkg::IDX_PORT_D: begin
                    cfg.port_d_push_pull <= wdat[5:0] & pcr_pkg::MSK_PORT_D[5:0];
                end
                pcr_pkg::IDX_PORT_E: begin
                    cfg.port_e_push_pull <= wdat[3:0] & pcr_pkg::MSK_PORT_E[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Pin routing is registered so outputs come from flops; one cycle of pin latency
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buzzer_pin_out <= 1'b0;
            buzzer_pin_oe <= 1'b0;
            pwm_a_pin_out <= 1'b0;
            pwm_a_pin_oe <= 1'b0;
            pwm_b_pin_out <= 1'b0;
            pwm_b_pin_oe <= 1'b0;
        end else begin
            buzzer_pin_out <= cfg.buzzer_pin_enable & buzzer_wave;
            buzzer_pin_oe <= cfg.buzzer_pin_enable;
            pwm_a_pin_out <= cfg.pwm_a_pin_enable & (pwm_a_wave ^ cfg.pwm_a_invert);
            pwm_a_pin_oe <= cfg.pwm_a_pin_enable;
            pwm_b_pin_out <= cfg.pwm_b_pin_enable & pwm_b_wave;
            pwm_b_pin_oe <= cfg.pwm_b_pin_enable;
        end
    end

    // Slow timer divider; a tick is one slow timer clock from the clock mux outside
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmr_cnt <= 15'h0000;
        end else if (slow_timer_tick) begin
            tmr_cnt <= tmr_cnt + 15'h0001;
        end
    end

    // Interrupt and display pulses one cycle after the tick that completes each division
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_timer_irq <= 1'b0;
            display_clock_tick <= 1'b0;
        end else begin
            slow_timer_irq <= slow_timer_tick && ((tmr_cnt & irq_mask) == irq_mask);
            display_clock_tick <= slow_timer_tick &&
                ((tmr_cnt[6:0] & disp_mask) == disp_mask);
        end
    end

    sequence s_wr_addr(logic [7:0] idx);
        hready && hsel && htrans[1] && hwrite && hsize == 3'h2 && pcr_index(haddr) == idx;
    endsequence

    AST_SLOW_OSC_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_addr(pcr_pkg::IDX_SLOW_OSC) ##1 1'b1 |=> cfg.watchdog_wake_period == $past(hwdata[1:0])
        && cfg.slow_rc_freq_select == $past(hwdata[6:5]))
        else $error("slow osc register not loaded");
    AST_TOUCH_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_addr(pcr_pkg::IDX_TOUCH) ##1 1'b1 |=> cfg.touch_channel_select == $past(hwdata[3:0]))
        else $error("touch channel not loaded");
    AST_PORT_D_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_addr(pcr_pkg::IDX_PORT_D) ##1 1'b1 |=> cfg.port_d_push_pull == $past(hwdata[5:0]))
        else $error("port d type not loaded");
    AST_DISP_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_addr(pcr_pkg::IDX_DISP) ##1 1'b1 |=> cfg.display_duty_select == $past(hwdata[5:3])
        && cfg.display_bias_select == $past(hwdata[2]))
        else $error("display register not loaded");
    AST_CLK_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_addr(pcr_pkg::IDX_CLK) ##1 1'b1 |=> cfg.crystal_high_gain == $past(hwdata[6])
        && cfg.slow_clock_type == $past(hwdata[1:0]))
        else $error("clock register not loaded");
    AST_BUZ_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
        !cfg.buzzer_pin_enable |=> !buzzer_pin_oe && !buzzer_pin_out)
        else $error("buzzer pin driven while disabled");
    AST_PWM_A_POL: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg.pwm_a_pin_enable |=> pwm_a_pin_out == ($past(pwm_a_wave) ^ $past(cfg.pwm_a_invert)))
        else $error("pwm a polarity wrong");
    AST_PWM_B_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg.pwm_b_pin_enable |=> pwm_b_pin_oe && pwm_b_pin_out == $past(pwm_b_wave))
        else $error("pwm b pin not driven");
    AST_IRQ_FAST: assert property (@(posedge hclk) disable iff (!hresetn)
        slow_timer_tick && cfg.slow_timer_irq_divide == 2'b11 && tmr_cnt[6:0] == 7'h7F
        |=> slow_timer_irq)
        else $error("slow timer irq missed at 128");
    AST_IRQ_SLOWEST: assert property (@(posedge hclk) disable iff (!hresetn)
        slow_timer_tick && cfg.slow_timer_irq_divide == 2'b00 && tmr_cnt == 15'h7FFF
        |=> slow_timer_irq)
        else $error("slow timer irq missed at 32768");
    AST_IRQ_SLOWEST_GAP: assert property (@(posedge hclk) disable iff (!hresetn)
        slow_timer_tick && cfg.slow_timer_irq_divide == 2'b00 && tmr_cnt != 15'h7FFF
        |=> !slow_timer_irq)
        else $error("slow timer irq off 32768 boundary");
    AST_IRQ_ONLY_TICK: assert property (@(posedge hclk) disable iff (!hresetn)
        !slow_timer_tick |=> !slow_timer_irq && !display_clock_tick)
        else $error("pulse without tick");
    AST_DISP_16: assert property (@(posedge hclk) disable iff (!hresetn)
        slow_timer_tick && cfg.display_clock_divide == 2'b11 && tmr_cnt[3:0] != 4'hF
        |=> !display_clock_tick)
        else $error("display tick off 16 boundary");
endmodule : pcr_regs
